// File: ebpc_pkg.sv
/*
 Constants and types for the external bus pin configuration block.
 Assumes a 10 MHz system clock and a simple strobe register port.
*/
// Behaviour
// - Each ready input is inverted before use when its invert bit is one.
// - Ready pin enable bits hand each ready pin to the bus interface.
// - Level sense bit one means level detect, zero means edge detect of ready.
// - RP control pin enable hands that pin to the bus interface.
// - Write strobe pin enable hands the write strobe pin to the interface.
// - Unimplemented bits, bit 28 among them, read zero and ignore writes.
// - Mode select high ignores the register; all pins stay general purpose.
package ebpc_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] EBPC_ASSIGN_OFFSET = 4'h0;
    localparam logic [31:0] EBPC_ASSIGN_RESET = 32'h0000_0000;
    localparam logic [31:0] EBPC_ASSIGN_MASK = 32'hee03_33f3;
    localparam int EBPC_INV_LSB = 29;
    localparam int EBPC_RDYEN_LSB = 25;
    localparam int EBPC_LVL_BIT = 17;
    localparam int EBPC_RP_BIT = 16;
    localparam int EBPC_WE_BIT = 13;
    localparam int EBPC_OE_BIT = 12;
    localparam int EBPC_BS_LSB = 8;
    localparam int EBPC_CS_LSB = 4;
    localparam int EBPC_DATA_LSB = 0;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ebpc_req_t;

    typedef struct packed {
        logic [2:0] rdy_en;
        logic rp_en;
        logic we_en;
        logic oe_en;
        logic [1:0] bs_en;
        logic [3:0] cs_en;
        logic [1:0] data_en;
    } ebpc_claim_t;

    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] rdata;
        ebpc_claim_t claim;
        logic [2:0] rdy_s1;
        logic [2:0] rdy_s2;
        logic [2:0] rdy_prev;
        logic [2:0] rdy_use;
        logic level;
    } ebpc_state_t;
endpackage

// File: ebpc_ready_dev.sv
/*
 Partner model: the external devices that drive the three ready pins.
 Assumes the bench sets the wanted levels; pins move after clock edges.
*/
`timescale 1ns/1ps
module ebpc_ready_dev (
    input wire logic clk_i,
    input wire logic [2:0] want_i,
    output logic [2:0] pin_o
);
    always @(posedge clk_i)
        pin_o <= want_i;
endmodule // ebpc_ready_dev

// File: ebpc_top.sv
/*
 External bus pin configuration register and ready pin conditioning.
 Assumes register strobes come from logic on clk_i; ready pins are asynchronous.
*/
`timescale 1ns/1ps
module ebpc_top (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input ebpc_pkg::ebpc_req_t req_i,
    input wire logic extbus_mode_select_i,
    input wire logic [2:0] extbus_ready_pin_i,
    output logic [31:0] rdata_o,
    output ebpc_pkg::ebpc_claim_t claim_o,
    output logic [2:0] ready_o,
    output logic ready_level_sense_o
);
    import ebpc_pkg::*;

    ebpc_state_t s_q;
    ebpc_state_t s_d;
    logic [2:0] inv;
    logic [2:0] en;
    logic [2:0] cond;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        if (req_i.wr && req_i.addr == EBPC_ASSIGN_OFFSET)
        begin
            s_d.cfg = req_i.wdata & EBPC_ASSIGN_MASK;
        end
        s_d.rdata = 32'h0000_0000;
        if (req_i.rd && req_i.addr == EBPC_ASSIGN_OFFSET)
        begin
            s_d.rdata = s_q.cfg;
        end
        inv = s_q.cfg[EBPC_INV_LSB +: 3];
        en = s_q.cfg[EBPC_RDYEN_LSB +: 3];
        if (extbus_mode_select_i)
        begin
            s_d.claim = '0;
            en = 3'h0;
        end
        else
        begin
            s_d.claim.rdy_en = en;
            s_d.claim.rp_en = s_q.cfg[EBPC_RP_BIT];
            s_d.claim.we_en = s_q.cfg[EBPC_WE_BIT];
            s_d.claim.oe_en = s_q.cfg[EBPC_OE_BIT];
            s_d.claim.bs_en = s_q.cfg[EBPC_BS_LSB +: 2];
            s_d.claim.cs_en = s_q.cfg[EBPC_CS_LSB +: 4];
            s_d.claim.data_en = s_q.cfg[EBPC_DATA_LSB +: 2];
        end
        s_d.rdy_s1 = extbus_ready_pin_i;
        s_d.rdy_s2 = s_q.rdy_s1;
        cond = s_q.rdy_s2 ^ inv;
        s_d.rdy_prev = cond;
        s_d.level = s_q.cfg[EBPC_LVL_BIT] & ~extbus_mode_select_i;
        // Level: follow the pin; edge: one-cycle pulse on each rising edge
        if (s_q.cfg[EBPC_LVL_BIT])
        begin
            s_d.rdy_use = cond & en;
        end
        else
        begin
            s_d.rdy_use = cond & ~s_q.rdy_prev & en;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
    assign claim_o = s_q.claim;
    assign ready_o = s_q.rdy_use;
    assign ready_level_sense_o = s_q.level;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence wr_cfg;
        req_i.wr && req_i.addr == EBPC_ASSIGN_OFFSET;
    endsequence

    a_reserved_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (s_q.cfg & ~EBPC_ASSIGN_MASK) == 32'h0 && !rdata_o[28])
        else $error("reserved bits not zero");
    a_read_data: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        req_i.rd && req_i.addr == EBPC_ASSIGN_OFFSET |=> rdata_o == $past(s_q.cfg))
        else $error("read data wrong");
    a_mode_release: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        extbus_mode_select_i |=> claim_o == '0 && ready_o == 3'h0)
        else $error("pins claimed in mode select");
    a_ready_claim: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !extbus_mode_select_i |=> claim_o.rdy_en == $past(s_q.cfg[27:25]))
        else $error("ready enable wrong");
    a_rp_claim: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !extbus_mode_select_i |=> claim_o.rp_en == $past(s_q.cfg[16]))
        else $error("rp enable wrong");
    a_we_claim: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wr_cfg ##1 !extbus_mode_select_i |=> claim_o.we_en == $past(req_i.wdata[13], 2))
        else $error("write strobe enable wrong");
    a_cs_claim: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !extbus_mode_select_i |=> claim_o.cs_en == $past(s_q.cfg[7:4]))
        else $error("chip select enable wrong");
    a_ready_inv: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_q.cfg[17] && s_q.cfg[25] && !extbus_mode_select_i
        |=> ready_o[0] == ($past(s_q.rdy_s2[0]) ^ $past(s_q.cfg[29])))
        else $error("ready inversion wrong");
    a_edge_pulse: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !s_q.cfg[17] ##1 !s_q.cfg[17] |=> !(ready_o[0] && $past(ready_o[0])))
        else $error("edge mode not a pulse");

    // ----------------------------------------------------------------
    // Register port checks
    // ----------------------------------------------------------------
    sequence rd_cfg;
        req_i.rd && req_i.addr == EBPC_ASSIGN_OFFSET;
    endsequence

    sequence bus_mode_off;
        !extbus_mode_select_i;
    endsequence

    a_write_lands: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wr_cfg |=> s_q.cfg == ($past(req_i.wdata) & EBPC_ASSIGN_MASK))
        else $error("write did not land");

    a_other_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        req_i.wr && req_i.addr != EBPC_ASSIGN_OFFSET |=> s_q.cfg == $past(s_q.cfg))
        else $error("write to other offset changed register");

    a_other_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        req_i.rd && req_i.addr != EBPC_ASSIGN_OFFSET |=> rdata_o == 32'h0000_0000)
        else $error("read of other offset not zero");

    a_idle_rdata: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !req_i.rd |=> rdata_o == 32'h0000_0000)
        else $error("read data without read strobe");

    a_read_masked: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        rd_cfg |=> (rdata_o & ~EBPC_ASSIGN_MASK) == 32'h0000_0000)
        else $error("read shows reserved bits");

    // ----------------------------------------------------------------
    // Pin claim and level sense checks
    // ----------------------------------------------------------------
    a_we_level: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        bus_mode_off |=> claim_o.we_en == $past(s_q.cfg[13]))
        else $error("write strobe claim wrong");

    a_data_claim: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        bus_mode_off |=> claim_o.data_en == $past(s_q.cfg[1:0]))
        else $error("data group claim wrong");

    a_oe_claim: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        bus_mode_off |=> claim_o.oe_en == $past(s_q.cfg[12]))
        else $error("output enable claim wrong");

    a_bs_claim: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        bus_mode_off |=> claim_o.bs_en == $past(s_q.cfg[9:8]))
        else $error("byte select claim wrong");

    a_mode_level: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        extbus_mode_select_i |=> !ready_level_sense_o)
        else $error("level sense shown in mode select");

    a_level_copy: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        bus_mode_off |=> ready_level_sense_o == $past(s_q.cfg[17]))
        else $error("level sense copy wrong");

    // ----------------------------------------------------------------
    // Ready path checks
    // ----------------------------------------------------------------
    a_ready1_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !s_q.cfg[25] |=> !ready_o[0])
        else $error("ready1 passed while not enabled");

    a_ready2_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !s_q.cfg[26] |=> !ready_o[1])
        else $error("ready2 passed while not enabled");

    a_ready3_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !s_q.cfg[27] |=> !ready_o[2])
        else $error("ready3 passed while not enabled");

    a_ready2_inv: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_q.cfg[17] && s_q.cfg[26] && !extbus_mode_select_i
        |=> ready_o[1] == ($past(s_q.rdy_s2[1]) ^ $past(s_q.cfg[30])))
        else $error("ready2 inversion wrong");

    a_ready3_inv: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_q.cfg[17] && s_q.cfg[27] && !extbus_mode_select_i
        |=> ready_o[2] == ($past(s_q.rdy_s2[2]) ^ $past(s_q.cfg[31])))
        else $error("ready3 inversion wrong");

    a_edge_rise: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !s_q.cfg[17] && s_q.cfg[25] && !extbus_mode_select_i
        |=> ready_o[0] == ($past(s_q.rdy_s2[0] ^ s_q.cfg[29]) && !$past(s_q.rdy_prev[0])))
        else $error("edge detect wrong");

    a_sync_chain: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        1'b1 |=> s_q.rdy_s2 == $past(s_q.rdy_s1))
        else $error("ready synchroniser skipped a stage");
endmodule // ebpc_top

// File: ebpc_top_bench.sv
/*
 Self-checking bench for the external bus pin configuration block.
 Assumes one-cycle register strobes and a 100 ns clock.
*/
`timescale 1ns/1ps
module ebpc_top_bench;
    import ebpc_pkg::*;
    logic clk_i = 0, arst_n_i = 0, mode = 0, lvl;
    logic [2:0] want = 0, pin, rdy;
    ebpc_req_t req = '0;
    logic [31:0] rdata;
    ebpc_claim_t claim;
    int bad_count = 0, checked = 0, n = 0;
    ebpc_top u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req),
        .extbus_mode_select_i(mode), .extbus_ready_pin_i(pin), .rdata_o(rdata),
        .claim_o(claim), .ready_o(rdy), .ready_level_sense_o(lvl));
    ebpc_ready_dev u_dev (.clk_i(clk_i), .want_i(want), .pin_o(pin));
    initial forever #50 clk_i = ~clk_i;
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i) req <= '0;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_i) req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_i) req <= '0;
        #1 chk("rdata", rdata, exp);
    endtask
    task cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task end_of_test;
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------
    // Tests
    // ----------------
    initial
    begin
        repeat (8) @(posedge clk_i);
        arst_n_i <= 1;
        rd(4'h0, 32'h0);
        chk("claim", claim, 32'h0);
        wr(4'h0, 32'hffff_ffff);
        rd(4'h0, EBPC_ASSIGN_MASK);
        chk("claim", claim, 32'h3fff);
        chk("lvl", lvl, 32'h1);
        wr(4'h4, 32'h0);
        rd(4'h4, 32'h0);
        rd(4'h0, EBPC_ASSIGN_MASK);
        @(posedge clk_i) mode <= 1;
        cyc(3);
        chk("mode claim", claim, 32'h0);
        chk("mode lvl", lvl, 32'h0);
        @(posedge clk_i) mode <= 0;
        wr(4'h0, 32'h0001_2000);
        cyc(2);
        chk("rp we", claim, 32'h0600);
        chk("we", claim[9], 32'h1);
        wr(4'h0, 32'h2202_0000);
        cyc(6);
        chk("inv", rdy, 32'h1);
        @(posedge clk_i) want <= 3'h7;
        cyc(6);
        chk("inv hi", rdy, 32'h0);
        wr(4'h0, 32'h0200_0000);
        @(posedge clk_i) want <= 3'h0;
        cyc(6);
        @(posedge clk_i) want <= 3'h1;
        repeat (10)
        begin
            cyc(1);
            if (rdy[0] === 1'b1)
                n++;
        end
        chk("edge", n, 32'h1);
        end_of_test;
    end
    initial
    begin
        #100000;
        bad_count++;
        end_of_test;
    end
endmodule // ebpc_top_bench
